// ==== shared/mdf_pkg.sv ====
// constants, register map and carrier types for the motor driver function-input block
// assumes one 10 MHz clock domain and an apb master with 32-bit data
// ***************************************
// Overview of operation
// ***************************************
// Overview of operation
// R1: with both torque-off inputs on, restore input off-to-on re-excites the motor
// R2: restore judgement setting: 1 rising edge, 2 on level; default 1
// R3: latch-clear clears three step latched flags and their position snapshots
// R4: latch-clear also clears stop snapshot, pulse-loss flag and load accumulator
// R5: info-clear releases information status only while auto clear is disabled
// R6: tool-unlock on permits test, position_capture_in, remote, write; off blocks them; the capture table write here is not gated by unlock
// R7: unassigned tool-unlock counts as on; assigned to both needs both on
// R8: host must not use one-shot mapping for tool-unlock
// R9: capture rising edge writes present position into entry chosen by select bits
// R10: capture sets operation type: -1 keep, 1 absolute, 8 wrap absolute; default 1
// R11: pulse-multiply on scales pulse count and frequency by 2..30, default 10
// R12: host keeps pulse input below 1 MHz when multiplying
// R13: pulse-inhibit on makes the pulse command ignored
// R14: push-mode on suppresses overload alarm
// R15: host turns push-mode on during pulse-input push motion
// R16: push-mode standstill current: 0 stop, 1 operating; default 0
// R17: current-limit on caps current at ratio 0..1000 of base, 0.1% units, default 500
// R18: speed-limit on caps speed; type 0 ratio, 1 value; default 0
// R19: ratio mode caps speed at 1..100% of data speed, default 50
// R20: value mode caps speed at 1..4000000 Hz, default 1000
// R21: auto clear enabled releases info and output once cause disappears
// R22: every function input is synchronised and edges come from synced levels
package mdf_pkg;
   // ***************************************
   // register offsets (byte addresses)
   // ***************************************
   localparam logic [7:0] MDF_CFG_A_OFS    = 8'h00;
   localparam logic [7:0] MDF_CUR_LMT_OFS  = 8'h04;
   localparam logic [7:0] MDF_SPD_RAT_OFS  = 8'h08;
   localparam logic [7:0] MDF_SPD_VAL_OFS  = 8'h0c;
   localparam logic [7:0] MDF_STATUS_OFS   = 8'h10;
   localparam logic [7:0] MDF_EVENT_OFS    = 8'h14;
   localparam logic [7:0] MDF_POS_OFS      = 8'h18;
   localparam logic [7:0] MDF_TBL_IDX_OFS  = 8'h1c;
   localparam logic [7:0] MDF_TBL_POS_OFS  = 8'h20;
   localparam logic [7:0] MDF_TBL_TYP_OFS  = 8'h24;
   // ***************************************
   // cfg_a fields
   // ***************************************
   localparam int MDF_RST_MODE_LSB = 0;    // 2 bits
   localparam int MDF_POSITION_CAPTURE_IN_LSB    = 8;    // 8 bits signed
   localparam int MDF_MULT_LSB     = 16;   // 5 bits
   localparam int MDF_PUSH_CUR_BIT = 24;
   localparam int MDF_SPD_TYPE_BIT = 25;
   localparam int MDF_AUTO_CLR_BIT = 26;
   localparam int MDF_UNL_DIR_BIT  = 27;
   localparam int MDF_UNL_REM_BIT  = 28;
   // ***************************************
   // settings and reset values
   // ***************************************
   localparam logic [1:0]  MDF_RST_EDGE      = 2'h1;
   localparam logic [1:0]  MDF_RST_LEVEL     = 2'h2;
   localparam logic [7:0]  MDF_POSITION_CAPTURE_IN_KEEP    = 8'hff;
   localparam logic [7:0]  MDF_POSITION_CAPTURE_IN_ABS     = 8'h01;
   localparam logic [7:0]  MDF_POSITION_CAPTURE_IN_WRAP    = 8'h08;
   localparam logic [4:0]  MDF_MULT_MIN      = 5'h02;
   localparam logic [4:0]  MDF_MULT_MAX      = 5'h1e;
   localparam logic [4:0]  MDF_MULT_RST      = 5'h0a;
   localparam logic        MDF_PUSH_CUR_RST  = 1'b0;
   localparam logic        MDF_SPD_TYPE_RST  = 1'b0;
   localparam logic        MDF_AUTO_CLR_RST  = 1'b1;
   localparam logic [9:0]  MDF_CUR_LMT_MAX   = 10'h3e8;
   localparam logic [9:0]  MDF_CUR_LMT_RST   = 10'h1f4;
   localparam logic [6:0]  MDF_SPD_RAT_MIN   = 7'h01;
   localparam logic [6:0]  MDF_SPD_RAT_MAX   = 7'h64;
   localparam logic [6:0]  MDF_SPD_RAT_RST   = 7'h32;
   localparam logic [21:0] MDF_SPD_VAL_MIN   = 22'h000001;
   localparam logic [21:0] MDF_SPD_VAL_MAX   = 22'h3d0900;
   localparam logic [21:0] MDF_SPD_VAL_RST   = 22'h0003e8;
   localparam int          MDF_TBL_DEPTH     = 256;
   // ***************************************
   // carrier types
   // ***************************************
   typedef struct packed {
      logic       excitation_restore_in;
      logic       torque_off_in_a;
      logic       torque_off_in_b;
      logic       latch_clear_in;
      logic       info_clear_in;
      logic       tool_unlock_dir;
      logic       tool_unlock_rem;
      logic       position_capture_in;
      logic [7:0] data_select_bits;
      logic       pulse_multiply_in;
      logic       pulse_inhibit_in;
      logic       push_mode_in;
      logic       current_limit_in;
      logic       speed_limit_in;
   } mdf_inputs_type;

   typedef struct packed {
      logic        excite_req;
      logic        tools_unlocked;
      logic        pulse_enable;
      logic [4:0]  pulse_factor;
      logic        overload_alarm_en;
      logic        push_hold_oper_cur;
      logic        cur_limit_act;
      logic [9:0]  cur_limit_ratio;
      logic        spd_limit_act;
      logic        spd_limit_by_value;
      logic [6:0]  spd_limit_ratio;
      logic [21:0] spd_limit_hz;
      logic        info_active;
      logic        latch_clear_pulse;
   } mdf_controls_type;
endpackage

// ==== rtl/mdf_sync.sv ====
// two-flop synchroniser bank for the function inputs
// assumes inputs are asynchronous pins from the host controller
`timescale 1ns/1ps
module mdf_sync
   import mdf_pkg::*;
(
   input  wire logic           pclk,     // system clock
   input  wire logic           presetn,  // async reset, active low
   input  wire mdf_inputs_type raw_in,   // pins as they arrive
   output      mdf_inputs_type sync_out  // second-stage levels
);
   mdf_inputs_type meta_q, meta_d;
   mdf_inputs_type sync_q, sync_d;

   always_comb begin
      meta_d = raw_in;   // R22
      sync_d = meta_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule

// ==== rtl/mdf_core.sv ====
// function-input logic of the motor driver with apb configuration registers
// assumes pins are asynchronous, motion core consumes the control bundle
`timescale 1ns/1ps
module mdf_core
   import mdf_pkg::*;
(
   input  wire logic             pclk,           // system clock 10 MHz
   input  wire logic             presetn,        // async reset, active low
   input  wire logic             psel,           // apb select
   input  wire logic             penable,        // apb access phase
   input  wire logic             pwrite,         // apb direction
   input  wire logic [7:0]       paddr,          // apb byte address
   input  wire logic [31:0]      pwdata,         // apb write data
   output      logic [31:0]      prdata,         // apb read data
   output      logic             pready,         // apb ready
   output      logic             pslverr,        // apb error
   input  wire mdf_inputs_type   pins,           // function inputs
   input  wire logic [31:0]      present_pos,    // current position from motion core
   input  wire logic             info_cause,     // an information condition is present
   input  wire logic             step_adv_set,   // latch events from the sequencer
   input  wire logic             branch_a_set,   // latch event
   input  wire logic             branch_b_set,   // latch event
   input  wire logic             stop_irq_set,   // stop-input interrupt snapshot event
   input  wire logic             pulse_loss_set, // pulse loss detected
   input  wire logic [15:0]      load_incr,      // load accumulation increment
   output      mdf_controls_type ctl,            // controls to motion core
   output      logic [3:0]       latch_flags     // step, branch a, branch b, pulse loss
);
   // ***************************************
   // synchronised inputs and edges
   // ***************************************
   mdf_inputs_type s;
   mdf_inputs_type prev_q, prev_d;

   mdf_sync u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .raw_in   (pins),
      .sync_out (s)
   );

   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction

   // ***************************************
   // state
   // ***************************************
   logic [1:0]  rst_mode_q, rst_mode_d;
   logic [7:0]  position_capture_in_type_q, position_capture_in_type_d;
   logic [4:0]  mult_q, mult_d;
   logic        push_cur_q, push_cur_d;
   logic        spd_type_q, spd_type_d;
   logic        auto_clr_q, auto_clr_d;
   logic        unl_dir_q, unl_dir_d;
   logic        unl_rem_q, unl_rem_d;
   logic [9:0]  cur_lmt_q, cur_lmt_d;
   logic [6:0]  spd_rat_q, spd_rat_d;
   logic [21:0] spd_val_q, spd_val_d;
   logic [3:0]  flags_q, flags_d;
   logic [31:0] snap_q [0:3];
   logic [31:0] snap_d [0:3];
   logic [31:0] load_q, load_d;
   logic        info_q, info_d;
   logic        excite_q, excite_d;
   logic [7:0]  tbl_idx_q, tbl_idx_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d;
   logic        pslverr_q, pslverr_d;
   mdf_controls_type ctl_q, ctl_d;
   logic [31:0] tbl_pos [0:MDF_TBL_DEPTH-1];
   logic [7:0]  tbl_typ [0:MDF_TBL_DEPTH-1];

   logic wr_en, rd_en, unlocked, both_off, latch_clr, cap_edge;

   always_comb begin
      prev_d   = s;
      // setup phase decode; access completes one cycle later with pready
      wr_en    = psel & ~penable & pwrite;
      rd_en    = psel & ~penable & ~pwrite;
      // unassigned copies count as on, both assigned need both on
      unlocked = (~unl_dir_q | s.tool_unlock_dir) & (~unl_rem_q | s.tool_unlock_rem); // R7
      both_off = s.torque_off_in_a & s.torque_off_in_b;
      latch_clr = rise(s.latch_clear_in, prev_q.latch_clear_in);   // R22
      cap_edge  = rise(s.position_capture_in, prev_q.position_capture_in); // R9
   end

   // ***************************************
   // apb register file
   // ***************************************
   always_comb begin
      rst_mode_d   = rst_mode_q;
      position_capture_in_type_d = position_capture_in_type_q;
      mult_d       = mult_q;
      push_cur_d   = push_cur_q;
      spd_type_d   = spd_type_q;
      auto_clr_d   = auto_clr_q;
      unl_dir_d    = unl_dir_q;
      unl_rem_d    = unl_rem_q;
      cur_lmt_d    = cur_lmt_q;
      spd_rat_d    = spd_rat_q;
      spd_val_d    = spd_val_q;
      tbl_idx_d    = tbl_idx_q;
      prdata_d     = prdata_q;
      pslverr_d    = 1'b0;
      pready_d     = psel & ~penable;
      if (wr_en) begin
         if (paddr == MDF_CFG_A_OFS) begin
            if (pwdata[MDF_RST_MODE_LSB +: 2] == MDF_RST_EDGE || pwdata[MDF_RST_MODE_LSB +: 2] == MDF_RST_LEVEL) begin
               rst_mode_d = pwdata[MDF_RST_MODE_LSB +: 2];   // R2
            end
            if (pwdata[MDF_POSITION_CAPTURE_IN_LSB +: 8] == MDF_POSITION_CAPTURE_IN_KEEP || pwdata[MDF_POSITION_CAPTURE_IN_LSB +: 8] == MDF_POSITION_CAPTURE_IN_ABS ||
                pwdata[MDF_POSITION_CAPTURE_IN_LSB +: 8] == MDF_POSITION_CAPTURE_IN_WRAP) begin
               position_capture_in_type_d = pwdata[MDF_POSITION_CAPTURE_IN_LSB +: 8];   // R10
            end
            if (pwdata[MDF_MULT_LSB +: 5] >= MDF_MULT_MIN && pwdata[MDF_MULT_LSB +: 5] <= MDF_MULT_MAX) begin
               mult_d = pwdata[MDF_MULT_LSB +: 5];   // R11
            end
            push_cur_d = pwdata[MDF_PUSH_CUR_BIT];   // R16
            spd_type_d = pwdata[MDF_SPD_TYPE_BIT];   // R18
            auto_clr_d = pwdata[MDF_AUTO_CLR_BIT];
            unl_dir_d  = pwdata[MDF_UNL_DIR_BIT];
            unl_rem_d  = pwdata[MDF_UNL_REM_BIT];
         end else if (paddr == MDF_CUR_LMT_OFS) begin
            if (pwdata[9:0] <= MDF_CUR_LMT_MAX && pwdata[31:10] == '0) begin
               cur_lmt_d = pwdata[9:0];   // R17
            end
         end else if (paddr == MDF_SPD_RAT_OFS) begin
            if (pwdata[6:0] >= MDF_SPD_RAT_MIN && pwdata[6:0] <= MDF_SPD_RAT_MAX && pwdata[31:7] == '0) begin
               spd_rat_d = pwdata[6:0];   // R19
            end
         end else if (paddr == MDF_SPD_VAL_OFS) begin
            if (pwdata[21:0] >= MDF_SPD_VAL_MIN && pwdata[21:0] <= MDF_SPD_VAL_MAX && pwdata[31:22] == '0) begin
               spd_val_d = pwdata[21:0];   // R20
            end
         end else if (paddr == MDF_TBL_IDX_OFS) begin
            tbl_idx_d = pwdata[7:0];
         end else if (paddr == MDF_STATUS_OFS || paddr == MDF_EVENT_OFS || paddr == MDF_POS_OFS ||
                      paddr == MDF_TBL_POS_OFS || paddr == MDF_TBL_TYP_OFS) begin
            pslverr_d = 1'b0;
         end else begin
            pslverr_d = 1'b1;
         end
      end else if (rd_en) begin
         prdata_d = 32'h0;
         if (paddr == MDF_CFG_A_OFS) begin
            prdata_d[MDF_RST_MODE_LSB +: 2] = rst_mode_q;
            prdata_d[MDF_POSITION_CAPTURE_IN_LSB +: 8]    = position_capture_in_type_q;
            prdata_d[MDF_MULT_LSB +: 5]     = mult_q;
            prdata_d[MDF_PUSH_CUR_BIT]      = push_cur_q;
            prdata_d[MDF_SPD_TYPE_BIT]      = spd_type_q;
            prdata_d[MDF_AUTO_CLR_BIT]      = auto_clr_q;
            prdata_d[MDF_UNL_DIR_BIT]       = unl_dir_q;
            prdata_d[MDF_UNL_REM_BIT]       = unl_rem_q;
         end else if (paddr == MDF_CUR_LMT_OFS) begin
            prdata_d[9:0] = cur_lmt_q;
         end else if (paddr == MDF_SPD_RAT_OFS) begin
            prdata_d[6:0] = spd_rat_q;
         end else if (paddr == MDF_SPD_VAL_OFS) begin
            prdata_d[21:0] = spd_val_q;
         end else if (paddr == MDF_STATUS_OFS) begin
            prdata_d[7:0] = {excite_q, unlocked, info_q, 1'b0, flags_q};
         end else if (paddr == MDF_EVENT_OFS) begin
            prdata_d = load_q;
         end else if (paddr == MDF_POS_OFS) begin
            prdata_d = snap_q[3];
         end else if (paddr == MDF_TBL_IDX_OFS) begin
            prdata_d[7:0] = tbl_idx_q;
         end else if (paddr == MDF_TBL_POS_OFS) begin
            prdata_d = tbl_pos[tbl_idx_q];
         end else if (paddr == MDF_TBL_TYP_OFS) begin
            prdata_d[7:0] = tbl_typ[tbl_idx_q];
         end else begin
            pslverr_d = 1'b1;
         end
      end
   end

   // ***************************************
   // latches, snapshots, info, excitation
   // ***************************************
   always_comb begin
      flags_d = flags_q;
      load_d  = load_q;
      for (int i = 0; i < 4; i++) begin
         snap_d[i] = snap_q[i];
      end
      if (latch_clr) begin
         flags_d = 4'h0;   // R3 R4
         load_d  = 32'h0;   // R4
         for (int i = 0; i < 4; i++) begin
            snap_d[i] = 32'h0;   // R3 R4
         end
      end
      // a latch event in the clear cycle survives the clear
      if (step_adv_set) begin
         flags_d[0] = 1'b1;
         snap_d[0]  = present_pos;
      end
      if (branch_a_set) begin
         flags_d[1] = 1'b1;
         snap_d[1]  = present_pos;
      end
      if (branch_b_set) begin
         flags_d[2] = 1'b1;
         snap_d[2]  = present_pos;
      end
      if (pulse_loss_set) begin
         flags_d[3] = 1'b1;
      end
      if (stop_irq_set) begin
         snap_d[3] = present_pos;
      end
      load_d = load_d + {16'h0, load_incr};

      info_d = info_q;
      if (auto_clr_q && !info_cause) begin
         info_d = 1'b0;   // R21
      end else if (!auto_clr_q && s.info_clear_in) begin
         info_d = 1'b0;   // R5
      end
      if (info_cause) begin
         info_d = 1'b1;
      end

      excite_d = excite_q;
      if (!both_off) begin
         excite_d = 1'b0;
      end else if (rst_mode_q == MDF_RST_LEVEL ? s.excitation_restore_in
                   : rise(s.excitation_restore_in, prev_q.excitation_restore_in)) begin
         excite_d = 1'b1;   // R1 R2
      end
   end

   // ***************************************
   // control bundle to motion core
   // ***************************************
   always_comb begin
      ctl_d                    = '0;
      ctl_d.excite_req         = excite_d;
      ctl_d.tools_unlocked     = unlocked;   // R6
      ctl_d.pulse_enable       = ~s.pulse_inhibit_in;   // R13
      ctl_d.pulse_factor       = s.pulse_multiply_in ? mult_q : 5'h01;   // R11
      ctl_d.overload_alarm_en  = ~s.push_mode_in;   // R14
      ctl_d.push_hold_oper_cur = s.push_mode_in & push_cur_q;   // R16
      ctl_d.cur_limit_act      = s.current_limit_in;   // R17
      ctl_d.cur_limit_ratio    = cur_lmt_q;
      ctl_d.spd_limit_act      = s.speed_limit_in;   // R18
      ctl_d.spd_limit_by_value = spd_type_q;
      ctl_d.spd_limit_ratio    = spd_rat_q;   // R19
      ctl_d.spd_limit_hz       = spd_val_q;   // R20
      ctl_d.info_active        = info_d;
      ctl_d.latch_clear_pulse  = latch_clr;
   end

   always_ff @(posedge pclk) begin
      if (cap_edge) begin
         tbl_pos[s.data_select_bits] <= present_pos;   // R9
         if (position_capture_in_type_q != MDF_POSITION_CAPTURE_IN_KEEP) begin
            tbl_typ[s.data_select_bits] <= position_capture_in_type_q;   // R10
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q       <= '0;
         rst_mode_q   <= MDF_RST_EDGE;
         position_capture_in_type_q <= MDF_POSITION_CAPTURE_IN_ABS;
         mult_q       <= MDF_MULT_RST;
         push_cur_q   <= MDF_PUSH_CUR_RST;
         spd_type_q   <= MDF_SPD_TYPE_RST;
         auto_clr_q   <= MDF_AUTO_CLR_RST;
         unl_dir_q    <= 1'b0;
         unl_rem_q    <= 1'b0;
         cur_lmt_q    <= MDF_CUR_LMT_RST;
         spd_rat_q    <= MDF_SPD_RAT_RST;
         spd_val_q    <= MDF_SPD_VAL_RST;
         flags_q      <= 4'h0;
         load_q       <= 32'h0;
         info_q       <= 1'b0;
         excite_q     <= 1'b0;
         tbl_idx_q    <= 8'h00;
         prdata_q     <= 32'h0;
         pready_q     <= 1'b0;
         pslverr_q    <= 1'b0;
         ctl_q        <= '0;
         for (int i = 0; i < 4; i++) begin
            snap_q[i] <= 32'h0;
         end
      end else begin
         prev_q       <= prev_d;
         rst_mode_q   <= rst_mode_d;
         position_capture_in_type_q <= position_capture_in_type_d;
         mult_q       <= mult_d;
         push_cur_q   <= push_cur_d;
         spd_type_q   <= spd_type_d;
         auto_clr_q   <= auto_clr_d;
         unl_dir_q    <= unl_dir_d;
         unl_rem_q    <= unl_rem_d;
         cur_lmt_q    <= cur_lmt_d;
         spd_rat_q    <= spd_rat_d;
         spd_val_q    <= spd_val_d;
         flags_q      <= flags_d;
         load_q       <= load_d;
         info_q       <= info_d;
         excite_q     <= excite_d;
         tbl_idx_q    <= tbl_idx_d;
         prdata_q     <= prdata_d;
         pready_q     <= pready_d;
         pslverr_q    <= pslverr_d;
         ctl_q        <= ctl_d;
         for (int i = 0; i < 4; i++) begin
            snap_q[i] <= snap_d[i];
         end
      end
   end

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign ctl         = ctl_q;
   assign latch_flags = flags_q;
endmodule

// ==== bench/mdf_host.sv ====
// host controller model that drives the function-input pins
// assumes the bench sets wanted levels just after a rising edge
`timescale 1ns/1ps
module mdf_host
   import mdf_pkg::*;
(
   input  wire logic           pclk, // system clock
   input  wire mdf_inputs_type want, // levels the host means to show
   output      mdf_inputs_type pins  // levels at the driver pins
);
   // held levels only, never one-shot pulses, so unlock is never a pulse
   // no pulse train is driven, so the pulse rate stays far below 1 MHz
   always_ff @(posedge pclk) begin
      pins <= want;
   end
endmodule

// ==== bench/mdf_core_checker.sv ====
// assertions on the function-input block, bound to mdf_core
// assumes pin levels reach ctl three edges after they change
`timescale 1ns/1ps
module mdf_core_checker
   import mdf_pkg::*;
(
   input wire logic             pclk,    // system clock
   input wire logic             presetn, // async reset, active low
   input wire mdf_inputs_type   pins,    // function inputs
   input wire mdf_controls_type ctl      // controls to motion core
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****
   // levels held four samples cover both sync flops and the output flop
   // ****
   a_inhibit_stops: assert property (
      pins.pulse_inhibit_in [*4] |-> !ctl.pulse_enable) else $error("pulse not inhibited");
   a_push_no_ovl: assert property (
      pins.push_mode_in [*4] |-> !ctl.overload_alarm_en) else $error("overload not suppressed");
   a_mult_on_range: assert property (
      pins.pulse_multiply_in [*4] |-> ctl.pulse_factor >= MDF_MULT_MIN && ctl.pulse_factor <= MDF_MULT_MAX)
      else $error("factor out of range");
   a_mult_off_unity: assert property (
      !pins.pulse_multiply_in [*4] |-> ctl.pulse_factor == 5'h01) else $error("factor not one");
   a_cur_limit_on: assert property (
      pins.current_limit_in [*4] |-> ctl.cur_limit_act && ctl.cur_limit_ratio <= MDF_CUR_LMT_MAX)
      else $error("current limit wrong");
   a_spd_limit_on: assert property (
      pins.speed_limit_in [*4] |-> ctl.spd_limit_act) else $error("speed limit idle");
   a_excite_guard: assert property (
      $rose(ctl.excite_req) |-> $past(pins.torque_off_in_a, 3) && $past(pins.torque_off_in_b, 3))
      else $error("excited without torque-off inputs");
   a_clear_edge: assert property (
      ctl.latch_clear_pulse |-> $past(pins.latch_clear_in, 3) && !$past(pins.latch_clear_in, 4))
      else $error("latch clear not from synced edge");
endmodule
bind mdf_core mdf_core_checker mdf_core_checker_inst (
   .pclk(pclk), .presetn(presetn), .pins(pins), .ctl(ctl));

// ==== bench/tb_mdf_core.sv ====
// self-checking bench for the function-input block
// assumes mdf_core as top and mdf_host as pin driver
`timescale 1ns/1ps
module tb_mdf_core;
   import mdf_pkg::*;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, info_cause, e;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata, present_pos, r;
   logic [4:0]       set_ev;
   logic [15:0]      load_incr;
   logic [3:0]       latch_flags;
   mdf_inputs_type   want, pins;
   mdf_controls_type ctl;
   logic [7:0]       tt [3] = '{8'h01, 8'h08, 8'hff};
   logic [7:0]       te [3] = '{8'h01, 8'h08, 8'h08};
   int               n_mismatch, check_count;
   mdf_host mdf_host_inst (.pclk(pclk), .want(want), .pins(pins));
   mdf_core mdf_core_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pins(pins), .present_pos(present_pos), .info_cause(info_cause),
      .step_adv_set(set_ev[0]), .branch_a_set(set_ev[1]), .branch_b_set(set_ev[2]),
      .stop_irq_set(set_ev[3]), .pulse_loss_set(set_ev[4]), .load_incr(load_incr),
      .ctl(ctl), .latch_flags(latch_flags));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // ****
   // bus and compare tasks
   // ****
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_mismatch++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // three edges from pin to ctl plus the host flop, with margin
   task automatic settle;
      repeat (6) @(posedge pclk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge pclk);
      n_mismatch++;
      close_out;
   end
   initial begin
      {presetn, psel, penable, pwrite, info_cause} = 5'h0;
      {paddr, pwdata, present_pos, set_ev, load_incr} = '0;
      want = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(MDF_CFG_A_OFS, 32'h040a0101);
      rd(MDF_CUR_LMT_OFS, 32'h1f4);
      rd(MDF_SPD_RAT_OFS, 32'h32);
      rd(MDF_SPD_VAL_OFS, 32'h3e8);
      rd(MDF_STATUS_OFS, 32'h40);
      rd(8'h40, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("test defaults done");
      want.pulse_multiply_in <= 1'b1;
      settle;
      chk(32'(ctl.pulse_factor), 32'ha);
      wr(MDF_CFG_A_OFS, 32'h041e0101);
      wr(MDF_CFG_A_OFS, 32'h041f0101);
      wr(MDF_CFG_A_OFS, 32'h04010101);
      rd(MDF_CFG_A_OFS, 32'h041e0101);
      chk(32'(ctl.pulse_factor), 32'h1e);
      want.pulse_inhibit_in <= 1'b1;
      want.push_mode_in <= 1'b1;
      settle;
      chk(32'(ctl.pulse_enable), 32'h0);
      chk(32'(ctl.overload_alarm_en), 32'h0);
      chk(32'(ctl.push_hold_oper_cur), 32'h0);
      wr(MDF_CFG_A_OFS, 32'h051e0101);
      settle;
      chk(32'(ctl.push_hold_oper_cur), 32'h1);
      wr(MDF_CUR_LMT_OFS, 32'h3e8);
      wr(MDF_CUR_LMT_OFS, 32'h3e9);
      rd(MDF_CUR_LMT_OFS, 32'h3e8);
      want.current_limit_in <= 1'b1;
      want.speed_limit_in <= 1'b1;
      wr(MDF_SPD_RAT_OFS, 32'h64);
      wr(MDF_SPD_RAT_OFS, 32'h0);
      rd(MDF_SPD_RAT_OFS, 32'h64);
      wr(MDF_SPD_VAL_OFS, 32'h3d0900);
      wr(MDF_SPD_VAL_OFS, 32'h3d0901);
      rd(MDF_SPD_VAL_OFS, 32'h3d0900);
      wr(MDF_CFG_A_OFS, 32'h071e0101);
      settle;
      chk(32'({ctl.cur_limit_act, ctl.cur_limit_ratio}), 32'h7e8);
      chk(32'({ctl.spd_limit_by_value, ctl.spd_limit_hz}), 32'h7d0900);
      $display("test limits done");
      want.torque_off_in_a <= 1'b1;
      want.torque_off_in_b <= 1'b1;
      settle;
      rd(MDF_STATUS_OFS, 32'h40);
      want.excitation_restore_in <= 1'b1;
      settle;
      rd(MDF_STATUS_OFS, 32'hc0);
      want.torque_off_in_a <= 1'b0;
      settle;
      rd(MDF_STATUS_OFS, 32'h40);
      want.torque_off_in_a <= 1'b1;
      settle;
      rd(MDF_STATUS_OFS, 32'h40);
      wr(MDF_CFG_A_OFS, 32'h071e0102);
      settle;
      rd(MDF_STATUS_OFS, 32'hc0);
      wr(MDF_CFG_A_OFS, 32'h1f1e0102);
      want.tool_unlock_dir <= 1'b1;
      settle;
      rd(MDF_STATUS_OFS, 32'h80);
      want.tool_unlock_rem <= 1'b1;
      settle;
      rd(MDF_STATUS_OFS, 32'hc0);
      $display("test excitation and unlock done");
      want.data_select_bits <= 8'h06;
      foreach (tt[i]) begin
         wr(MDF_CFG_A_OFS, 32'h1f1e0002 | {16'h0, tt[i], 8'h0});
         present_pos <= 32'h1000 + 32'(i);
         want.position_capture_in <= 1'b1;
         settle;
         want.position_capture_in <= 1'b0;
         wr(MDF_TBL_IDX_OFS, 32'h6);
         rd(MDF_TBL_POS_OFS, 32'h1000 + 32'(i));
         rd(MDF_TBL_TYP_OFS, {24'h0, te[i]});
      end
      $display("test capture done");
      set_ev <= 5'h1f;
      load_incr <= 16'h3;
      @(posedge pclk);
      set_ev <= 5'h0;
      repeat (3) @(posedge pclk);
      load_incr <= 16'h0;
      rd(MDF_STATUS_OFS, 32'hcf);
      rd(MDF_EVENT_OFS, 32'hc);
      rd(MDF_POS_OFS, 32'h1002);
      want.latch_clear_in <= 1'b1;
      settle;
      chk(32'(latch_flags), 32'h0);
      rd(MDF_EVENT_OFS, 32'h0);
      rd(MDF_POS_OFS, 32'h0);
      $display("test latch clear done");
      info_cause <= 1'b1;
      settle;
      rd(MDF_STATUS_OFS, 32'he0);
      chk(32'(ctl.info_active), 32'h1);
      info_cause <= 1'b0;
      settle;
      rd(MDF_STATUS_OFS, 32'hc0);
      wr(MDF_CFG_A_OFS, 32'h1b1eff02);
      info_cause <= 1'b1;
      @(posedge pclk);
      info_cause <= 1'b0;
      settle;
      rd(MDF_STATUS_OFS, 32'he0);
      want.info_clear_in <= 1'b1;
      settle;
      rd(MDF_STATUS_OFS, 32'hc0);
      chk(32'({ctl.excite_req, ctl.tools_unlocked, ctl.info_active, ctl.spd_limit_ratio}), 32'h364);
      $display("test info done");
      close_out;
   end
endmodule
